// ### rtl/scb_config_bank.sv
// configuration register bank of a six-output differential clock buffer
// assumes a serial management bus whose clock and data pins are sampled
// on LINK_CLK_I; output controls leave on CLK_I
//
// What this block does
// - acknowledge write address and start index
// - after repeated start, acknowledge read address
// - send byte count, then registers ascending
// - release bus on host not-acknowledge
// - register 0: six enables, reset enabled
// - cleared enable forces output low
// - register 1 top bits: latched mode
// - override bit picks software or latched mode
// - software mode ignored unless override set
// - two swing bits, reset 10, bit2 one
// - register 2: six edge-rate bits, reset fast
// - frequency field active only when enabled
// - feedback edge bit, bits 1 and 2 read one, bits 6 and 7 read zero
// - register 4 always reads all ones
// - register 5: fixed revision and vendor
// - register 6: fixed class and part code
// - register 7 byte count, resets to 8
// - block write: count then data, acknowledged
// - target address latched from select strap
`timescale 1ns/1ns
`default_nettype none

module scb_config_bank #(
   parameter logic [3:0] REV_CODE = 4'hA,   // arbitrary value
   parameter logic [3:0] VENDOR_CODE = 4'h5, // arbitrary value
   parameter logic [1:0] PART_CLASS = 2'h2,  // arbitrary value
   parameter logic [5:0] PART_CODE = 6'h2A   // arbitrary value
) (
   input wire logic CLK_I,                              // core clock
   input wire logic RST_B_I,                            // async reset, low
   input wire logic LINK_CLK_I,                         // bus sampling clock
   input wire logic SMB_CLK_I,                          // bus clock pin
   input wire logic SMB_DAT_I,                          // bus data pin in
   output logic SMB_DAT_O,                              // bus data out, low
   output logic SMB_DAT_OE_O,                           // bus data drive
   input wire logic [scb_pkg::SEL_W-1:0] ADDR_SEL_I,    // address strap
   input wire logic [1:0] PLL_STRAP_I,                  // mode strap
   input wire logic [scb_pkg::NUM_OUT-1:0] OUT_EN_B_I,  // enable pins, low
   output logic [scb_pkg::NUM_OUT-1:0] DIFF_OUT_ON_O,   // output running
   output logic [1:0] PLL_MODE_O,                       // effective mode
   output logic [1:0] SWING_O,                          // amplitude code
   output logic [scb_pkg::NUM_OUT-1:0] EDGE_FAST_O,     // fast edges
   output logic FDBK_FAST_O,                            // feedback fast
   output logic FREQ_SW_EN_O,                           // sw freq select on
   output logic [1:0] FREQ_SEL_O                        // effective freq
);
   import scb_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic clk_s1, clk_s2, clk_d;
      logic dat_s1, dat_s2, dat_d;
      logic [1:0] sel_s1, sel_s2;
      logic [1:0] strap_s1, strap_s2;
      logic [1:0] settle;
      logic latched;
      logic [6:0] my_addr;
      logic [1:0] pll_rb;
      scb_state_t state;
      scb_phase_t phase;
      logic rd;
      logic [3:0] bitcnt;
      logic [7:0] shift, tx, index, wcount;
      logic dat_oe;
      logic [7:0] en, pll, edge_r, freq, cnt;
      logic dirty;
      logic req;
      logic ack_s1, ack_s2;
      logic [7:0] snap_en, snap_pll, snap_edge, snap_freq;
      logic [1:0] snap_rb;
   } scb_link_t;

   typedef struct packed {
      logic req_s1, req_s2;
      logic ack;
      logic [7:0] en, pll, edge_r, freq;
      logic [1:0] rb;
      logic [NUM_OUT-1:0] oe_s1, oe_s2, diff_on;
      logic [1:0] pll_mode, swing;
      logic [NUM_OUT-1:0] edge_fast;
      logic fdbk_fast;
      logic freq_en;
      logic [1:0] freq_sel;
   } scb_core_t;

   scb_link_t l;
   scb_link_t next_l;
   scb_core_t c;
   scb_core_t next_c;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // gathers the six per-output bits out of a register byte
   function automatic logic [NUM_OUT-1:0] pick_outs(input logic [7:0] b);
      logic [NUM_OUT-1:0] v;
      v = '0;
      for (int i = 0; i < NUM_OUT; i++) begin
         v[i] = b[OUT_POS[i]];
      end
      return v;
   endfunction

   function automatic logic [6:0] addr_of(input logic [1:0] sel);
      return (sel == SEL_LOW) ? ADDR_LOW : ((sel == SEL_MID) ? ADDR_MID : ADDR_HIGH);
   endfunction

   // register contents as seen by a read
   function automatic logic [7:0] read_byte(input scb_link_t s, input logic [7:0] idx);
      logic [7:0] v;
      v = 8'h00;
      case (idx)
         IDX_OUT_EN: v = s.en;
         IDX_PLL_SWING: v = {s.pll_rb, s.pll[5:0] | FIX_PLL_SWING[5:0]};
         IDX_EDGE: v = s.edge_r | FIX_EDGE;
         IDX_FREQ: v = s.freq | FIX_FREQ;
         IDX_RSVD: v = RSVD_VALUE;
         IDX_REV_VEN: v = {REV_CODE, VENDOR_CODE};
         IDX_DEV: v = {PART_CLASS, PART_CODE};
         IDX_COUNT: v = s.cnt;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   // ------------------------------------------------------------
   // link domain: bus target
   // ------------------------------------------------------------
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   always_comb begin
      next_l = l;
      scl_rise = l.clk_s2 & ~l.clk_d;
      scl_fall = ~l.clk_s2 & l.clk_d;
      bus_start = l.clk_s2 & l.clk_d & l.dat_d & ~l.dat_s2;
      bus_stop = l.clk_s2 & l.clk_d & ~l.dat_d & l.dat_s2;

      {next_l.clk_s1, next_l.clk_s2, next_l.clk_d} = {SMB_CLK_I, l.clk_s1, l.clk_s2};
      {next_l.dat_s1, next_l.dat_s2, next_l.dat_d} = {SMB_DAT_I, l.dat_s1, l.dat_s2};
      {next_l.sel_s1, next_l.sel_s2} = {ADDR_SEL_I, l.sel_s1};
      {next_l.strap_s1, next_l.strap_s2} = {PLL_STRAP_I, l.strap_s1};
      {next_l.ack_s1, next_l.ack_s2} = {c.ack, l.ack_s1};

      // straps caught once after reset release, then frozen
      if (!l.latched) begin
         if (l.settle == STRAP_SETTLE) begin
            next_l.my_addr = addr_of(l.sel_s2);
            next_l.pll_rb = l.strap_s2;
            next_l.latched = 1'b1;
         end else begin
            next_l.settle = l.settle + 2'h1;
         end
      end

      // after the strap latch, so the mode readback crosses as well
      if (l.dirty && l.latched && (l.req == l.ack_s2)) begin
         next_l.snap_en = l.en;
         next_l.snap_pll = l.pll;
         next_l.snap_edge = l.edge_r;
         next_l.snap_freq = l.freq;
         next_l.snap_rb = l.pll_rb;
         next_l.req = ~l.req;
         next_l.dirty = 1'b0;
      end

      if (!l.latched) begin
         next_l.state = ST_IDLE;
      end else if (bus_stop) begin
         next_l.state = ST_IDLE;
         next_l.dat_oe = 1'b0;
      end else if (bus_start) begin
         next_l.state = ST_RX;
         next_l.phase = PH_ADDR;
         next_l.bitcnt = 4'h0;
         next_l.rd = 1'b0;
         next_l.dat_oe = 1'b0;
      end else begin
         unique case (l.state)
            ST_IDLE, ST_WAIT: next_l.dat_oe = 1'b0;
            ST_RX: begin
               if (scl_rise && (l.bitcnt != BITS_PER_BYTE)) begin
                  next_l.shift = {l.shift[6:0], l.dat_s2};
                  next_l.bitcnt = l.bitcnt + 4'h1;
               end else if (scl_fall && (l.bitcnt == BITS_PER_BYTE)) begin
                  next_l.state = ST_ACK;
                  next_l.dat_oe = 1'b1;
                  unique case (l.phase)
                     PH_ADDR: begin
                        if (l.shift[7:1] == l.my_addr) begin
                           next_l.rd = l.shift[0];
                           next_l.phase = PH_INDEX;
                        end else begin
                           next_l.state = ST_WAIT;
                           next_l.dat_oe = 1'b0;
                        end
                     end
                     PH_INDEX: begin
                        next_l.index = l.shift;
                        next_l.phase = PH_COUNT;
                     end
                     PH_COUNT: begin
                        next_l.wcount = l.shift;
                        next_l.phase = PH_DATA;
                     end
                     PH_DATA: begin
                        if (l.wcount == 8'h00) begin
                           next_l.state = ST_WAIT;
                           next_l.dat_oe = 1'b0;
                        end else begin
                           next_l.wcount = l.wcount - 8'h01;
                           next_l.index = l.index + 8'h01;
                           case (l.index)
                              IDX_OUT_EN: begin
                                 next_l.en = l.shift & WM_OUT_EN;
                                 next_l.dirty = 1'b1;
                              end
                              IDX_PLL_SWING: begin
                                 next_l.pll = l.shift & WM_PLL_SWING;
                                 next_l.dirty = 1'b1;
                              end
                              IDX_EDGE: begin
                                 next_l.edge_r = l.shift & WM_EDGE;
                                 next_l.dirty = 1'b1;
                              end
                              IDX_FREQ: begin
                                 next_l.freq = l.shift & WM_FREQ;
                                 next_l.dirty = 1'b1;
                              end
                              IDX_COUNT: next_l.cnt = l.shift & WM_COUNT;
                              default: next_l.cnt = l.cnt;
                           endcase
                        end
                     end
                     default: begin
                        next_l.state = ST_WAIT;
                        next_l.dat_oe = 1'b0;
                     end
                  endcase
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  next_l.bitcnt = 4'h0;
                  if (l.rd) begin
                     next_l.tx = l.cnt;
                     next_l.dat_oe = ~l.cnt[7];
                     next_l.state = ST_TX;
                  end else begin
                     next_l.dat_oe = 1'b0;
                     next_l.state = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  next_l.bitcnt = l.bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (l.bitcnt == BITS_PER_BYTE) begin
                     next_l.dat_oe = 1'b0;
                     next_l.state = ST_TXACK;
                  end else begin
                     next_l.tx = {l.tx[6:0], 1'b0};
                     next_l.dat_oe = ~l.tx[6];
                  end
               end
            end
            ST_TXACK: begin
               if (scl_rise) begin
                  if (l.dat_s2) begin
                     next_l.state = ST_WAIT;
                  end else begin
                     next_l.bitcnt = 4'h0;
                  end
               end else if (scl_fall && (l.bitcnt == 4'h0)) begin
                  next_l.tx = read_byte(l, l.index);
                  next_l.dat_oe = ~next_l.tx[7];
                  next_l.index = l.index + 8'h01;
                  next_l.state = ST_TX;
               end
            end
            default: begin
               next_l.state = ST_IDLE;
               next_l.dat_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge LINK_CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         l <= '0;
         l.clk_s1 <= 1'b1;
         l.clk_s2 <= 1'b1;
         l.clk_d <= 1'b1;
         l.dat_s1 <= 1'b1;
         l.dat_s2 <= 1'b1;
         l.dat_d <= 1'b1;
         l.state <= ST_IDLE;
         l.phase <= PH_ADDR;
         l.en <= RST_OUT_EN;
         l.pll <= RST_PLL_SWING;
         l.edge_r <= RST_EDGE;
         l.freq <= RST_FREQ;
         l.cnt <= RST_COUNT;
         l.dirty <= 1'b1;
      end else begin
         l <= next_l;
      end
   end

   // ------------------------------------------------------------
   // core domain: capture controls, drive outputs
   // ------------------------------------------------------------
   always_comb begin
      next_c = c;
      next_c.req_s1 = l.req;
      next_c.req_s2 = c.req_s1;
      next_c.oe_s1 = OUT_EN_B_I;
      next_c.oe_s2 = c.oe_s1;

      // snapshot is held still until this toggle is echoed back
      if (c.req_s2 != c.ack) begin
         next_c.en = l.snap_en;
         next_c.pll = l.snap_pll;
         next_c.edge_r = l.snap_edge;
         next_c.freq = l.snap_freq;
         next_c.rb = l.snap_rb;
         next_c.ack = c.req_s2;
      end

      next_c.diff_on = pick_outs(c.en) & ~c.oe_s2;
      next_c.pll_mode = c.pll[PLL_SW_OVR] ? c.pll[PLL_SW_HI:PLL_SW_LO] : c.rb;
      next_c.swing = c.pll[SWING_HI:SWING_LO];
      next_c.edge_fast = pick_outs(c.edge_r);
      next_c.fdbk_fast = c.freq[FDBK_EDGE];
      next_c.freq_en = c.freq[FREQ_EN];
      next_c.freq_sel = c.freq[FREQ_EN] ? c.freq[FREQ_HI:FREQ_LO] : 2'h0;
   end

   always_ff @(posedge CLK_I or negedge RST_B_I) begin
      if (!RST_B_I) begin
         c <= '0;
         c.en <= RST_OUT_EN;
         c.pll <= RST_PLL_SWING;
         c.edge_r <= RST_EDGE;
         c.freq <= RST_FREQ;
         c.oe_s1 <= '1;
         c.oe_s2 <= '1;
         c.swing <= RST_PLL_SWING[SWING_HI:SWING_LO];
         c.edge_fast <= '1;
         c.fdbk_fast <= 1'b1;
      end else begin
         c <= next_c;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign SMB_DAT_O = 1'b0;
   assign SMB_DAT_OE_O = l.dat_oe;
   assign DIFF_OUT_ON_O = c.diff_on;
   assign PLL_MODE_O = c.pll_mode;
   assign SWING_O = c.swing;
   assign EDGE_FAST_O = c.edge_fast;
   assign FDBK_FAST_O = c.fdbk_fast;
   assign FREQ_SW_EN_O = c.freq_en;
   assign FREQ_SEL_O = c.freq_sel;

endmodule

`default_nettype wire

// ### rtl/scb_pkg.sv
// constants and types of the clock buffer configuration bank
// imported by the bank module scb_config_bank, its checker and the bench
package scb_pkg;

   // ------------------------------------------------------------
   // register indices
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_OUT_EN = 8'h00;
   localparam logic [7:0] IDX_PLL_SWING = 8'h01;
   localparam logic [7:0] IDX_EDGE = 8'h02;
   localparam logic [7:0] IDX_FREQ = 8'h03;
   localparam logic [7:0] IDX_RSVD = 8'h04;
   localparam logic [7:0] IDX_REV_VEN = 8'h05;
   localparam logic [7:0] IDX_DEV = 8'h06;
   localparam logic [7:0] IDX_COUNT = 8'h07;

   // ------------------------------------------------------------
   // reset values, writable masks, fixed bits
   // ------------------------------------------------------------
   localparam logic [7:0] RST_OUT_EN = 8'hDD;
   localparam logic [7:0] RST_PLL_SWING = 8'h02;
   localparam logic [7:0] RST_EDGE = 8'hDD;
   localparam logic [7:0] RST_FREQ = 8'h01;
   localparam logic [7:0] RST_COUNT = 8'h08;
   localparam logic [7:0] WM_OUT_EN = 8'hDD;
   localparam logic [7:0] WM_PLL_SWING = 8'h3B;
   localparam logic [7:0] WM_EDGE = 8'hDD;
   localparam logic [7:0] WM_FREQ = 8'h39;
   localparam logic [7:0] WM_COUNT = 8'h1F;
   localparam logic [7:0] FIX_PLL_SWING = 8'h04;
   localparam logic [7:0] FIX_EDGE = 8'h02;
   localparam logic [7:0] FIX_FREQ = 8'h06;
   localparam logic [7:0] RSVD_VALUE = 8'hFF;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int PLL_SW_OVR = 5;
   localparam int PLL_SW_HI = 4;
   localparam int PLL_SW_LO = 3;
   localparam int SWING_HI = 1;
   localparam int SWING_LO = 0;
   localparam int FREQ_EN = 5;
   localparam int FREQ_HI = 4;
   localparam int FREQ_LO = 3;
   localparam int FDBK_EDGE = 0;
   localparam int NUM_OUT = 6;
   localparam int OUT_POS [0:NUM_OUT-1] = '{0, 2, 3, 4, 6, 7};

   // ------------------------------------------------------------
   // target addresses and strap decode
   // ------------------------------------------------------------
   localparam int SEL_W = 2;
   localparam logic [1:0] SEL_LOW = 2'h0;
   localparam logic [1:0] SEL_MID = 2'h1;
   localparam logic [6:0] ADDR_LOW = 7'h6B;
   localparam logic [6:0] ADDR_MID = 7'h6C;
   localparam logic [6:0] ADDR_HIGH = 7'h6D;

   // ------------------------------------------------------------
   // counts
   // ------------------------------------------------------------
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_RX = 6'b000010,
      ST_ACK = 6'b000100,
      ST_TX = 6'b001000,
      ST_TXACK = 6'b010000,
      ST_WAIT = 6'b100000
   } scb_state_t;

   typedef enum logic [3:0] {
      PH_ADDR = 4'b0001,
      PH_INDEX = 4'b0010,
      PH_COUNT = 4'b0100,
      PH_DATA = 4'b1000
   } scb_phase_t;

endpackage

// ### dv/scb_config_bank_checker.sv
// port assertions of the configuration bank
// assumes binding to scb_config_bank; pins seen at its ports
`timescale 1ns/1ns
`default_nettype none
module scb_config_bank_checker
   import scb_pkg::*;
(
   input wire logic CLK_I,                             // core clock
   input wire logic RST_B_I,                           // reset, low
   input wire logic LINK_CLK_I,                        // link clock
   input wire logic SMB_CLK_I,                         // bus clock
   input wire logic SMB_DAT_O,                         // data out
   input wire logic SMB_DAT_OE_O,                      // data drive
   input wire logic [scb_pkg::NUM_OUT-1:0] OUT_EN_B_I, // enable pins
   input wire logic [scb_pkg::NUM_OUT-1:0] DIFF_OUT_ON_O, // running
   input wire logic [1:0] PLL_MODE_O,                  // mode
   input wire logic [1:0] SWING_O,                     // swing
   input wire logic [scb_pkg::NUM_OUT-1:0] EDGE_FAST_O, // edges
   input wire logic FDBK_FAST_O,                       // feedback edge
   input wire logic FREQ_SW_EN_O,                      // freq enable
   input wire logic [1:0] FREQ_SEL_O                   // freq select
);
   // ------------------------------------------------------------
   // link side
   // ------------------------------------------------------------
   a_dat_only_low: assert property (@(posedge LINK_CLK_I) disable iff (!RST_B_I) !SMB_DAT_O)
      else $error("data output not low");
   a_oe_clk_low: assert property (@(posedge LINK_CLK_I) disable iff (!RST_B_I)
      $changed(SMB_DAT_OE_O) |-> !SMB_CLK_I) else $error("data moved while clock high");
   a_rst_no_drive: assert property (@(posedge LINK_CLK_I) disable iff (!RST_B_I)
      $rose(RST_B_I) |-> !SMB_DAT_OE_O) else $error("data driven after reset");
   // ------------------------------------------------------------
   // core side
   // ------------------------------------------------------------
   a_pin_forces_off: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      (DIFF_OUT_ON_O & OUT_EN_B_I & $past(OUT_EN_B_I, 1) & $past(OUT_EN_B_I, 2) & $past(OUT_EN_B_I, 3)
      & $past(OUT_EN_B_I, 4)) == '0) else $error("output on with pin high");
   a_freq_gated: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      !FREQ_SW_EN_O |-> FREQ_SEL_O == 2'h0) else $error("freq select without enable");
   a_rst_swing: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      $rose(RST_B_I) |-> SWING_O == 2'h2) else $error("swing reset wrong");
   a_rst_edges: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      $rose(RST_B_I) |-> EDGE_FAST_O == 6'h3F && FDBK_FAST_O) else $error("edge reset wrong");
   a_rst_modes: assert property (@(posedge CLK_I) disable iff (!RST_B_I)
      $rose(RST_B_I) |-> PLL_MODE_O == 2'h0 && !FREQ_SW_EN_O) else $error("mode reset wrong");
   c_dev_drive: cover property (@(posedge LINK_CLK_I) disable iff (!RST_B_I) $rose(SMB_DAT_OE_O));
   c_freq_on: cover property (@(posedge CLK_I) disable iff (!RST_B_I) $rose(FREQ_SW_EN_O));
   c_out_off: cover property (@(posedge CLK_I) disable iff (!RST_B_I) DIFF_OUT_ON_O == 6'h00);
endmodule
bind scb_config_bank scb_config_bank_checker chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I),
   .LINK_CLK_I(LINK_CLK_I), .SMB_CLK_I(SMB_CLK_I), .SMB_DAT_O(SMB_DAT_O), .SMB_DAT_OE_O(SMB_DAT_OE_O),
   .OUT_EN_B_I(OUT_EN_B_I), .DIFF_OUT_ON_O(DIFF_OUT_ON_O), .PLL_MODE_O(PLL_MODE_O), .SWING_O(SWING_O),
   .EDGE_FAST_O(EDGE_FAST_O), .FDBK_FAST_O(FDBK_FAST_O), .FREQ_SW_EN_O(FREQ_SW_EN_O),
   .FREQ_SEL_O(FREQ_SEL_O));
`default_nettype wire

// ### dv/scb_host_model.sv
// bus host model: open-drain data with pull-up, clock paced by clk_i
// assumes half periods of 10 clk_i cycles are slow enough for the target
`timescale 1ns/1ns
`default_nettype none
module scb_host_model (
   input wire logic clk_i,    // pacing clock
   input wire logic dev_oe_i, // target pulls data low
   output logic scl_o,        // bus clock
   output logic sda_o         // resolved data wire
);
   logic host_oe = 1'b0;
   initial scl_o = 1'b1;
   assign sda_o = !(host_oe || dev_oe_i);
   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   task automatic half();
      repeat (10) @(posedge clk_i);
   endtask
   task automatic start();
      repeat (2) @(posedge clk_i);
      host_oe <= 1'b0;
      half();
      scl_o <= 1'b1;
      half();
      host_oe <= 1'b1;
      half();
      scl_o <= 1'b0;
   endtask
   task automatic stop();
      repeat (2) @(posedge clk_i);
      host_oe <= 1'b1;
      half();
      scl_o <= 1'b1;
      half();
      host_oe <= 1'b0;
      half();
   endtask
   task automatic bit_io(input logic b, output logic r);
      repeat (2) @(posedge clk_i);
      host_oe <= !b;
      half();
      scl_o <= 1'b1;
      half();
      r = sda_o;
      scl_o <= 1'b0;
   endtask
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(d[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic get_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(!ack, r);
   endtask
endmodule
`default_nettype wire

// ### dv/test_smbus_clock_buffer_config_bank.sv
// self-checking bench of the configuration bank
// assumes scb_host_model on the bus and the bound checker
`timescale 1ns/1ns
`default_nettype none
module test_smbus_clock_buffer_config_bank;
   import scb_pkg::*;
   localparam logic [3:0] REV = 4'h3;   // arbitrary value
   localparam logic [3:0] VEN = 4'hC;   // arbitrary value
   localparam logic [1:0] CLS = 2'h3;   // arbitrary value
   localparam logic [5:0] CODE = 6'h15; // arbitrary value
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [1:0] addr_sel = 2'h0;
   logic [1:0] pll_strap = 2'h0;
   logic [5:0] en_b = 6'h00;
   logic scl, sda, dat_o, dat_oe, fdbk_fast, freq_en;
   logic [1:0] pll_mode, swing, freq_sel;
   logic [5:0] diff_on, edge_fast;
   logic [6:0] addr;
   logic [7:0] rm [0:7];
   int num_errors = 0;
   int total_checks = 0;
   initial forever #20 clk = ~clk;
   initial begin
      #7;
      forever #16 link_clk = ~link_clk;
   end
   scb_config_bank #(.REV_CODE(REV), .VENDOR_CODE(VEN), .PART_CLASS(CLS), .PART_CODE(CODE)) uut (
      .CLK_I(clk), .RST_B_I(rst_b), .LINK_CLK_I(link_clk), .SMB_CLK_I(scl), .SMB_DAT_I(sda),
      .SMB_DAT_O(dat_o), .SMB_DAT_OE_O(dat_oe), .ADDR_SEL_I(addr_sel), .PLL_STRAP_I(pll_strap),
      .OUT_EN_B_I(en_b), .DIFF_OUT_ON_O(diff_on), .PLL_MODE_O(pll_mode), .SWING_O(swing),
      .EDGE_FAST_O(edge_fast), .FDBK_FAST_O(fdbk_fast), .FREQ_SW_EN_O(freq_en), .FREQ_SEL_O(freq_sel));
   scb_host_model host (.clk_i(clk), .dev_oe_i(dat_oe), .scl_o(scl), .sda_o(sda));
   // ------------------------------------------------------------
   // expectation and checking
   // ------------------------------------------------------------
   function automatic logic [5:0] map6(input logic [7:0] b);
      return {b[7], b[6], b[4], b[3], b[2], b[0]};
   endfunction
   function automatic logic [7:0] wval(input int idx, input logic [7:0] d);
      case (idx)
         0: return d & 8'hDD;
         1: return {rm[1][7:6], d[5:3], 1'b1, d[1:0]};
         2: return (d & 8'hDD) | 8'h02;
         3: return (d & 8'h39) | 8'h06;
         7: return d & 8'h1F;
         default: return rm[idx];
      endcase
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic check_outs();
      check(8'(swing), 8'(rm[1][1:0]));
      check(8'(pll_mode), 8'(rm[1][5] ? rm[1][4:3] : rm[1][7:6]));
      check(8'(edge_fast), 8'(map6(rm[2])));
      check(8'(fdbk_fast), 8'(rm[3][0]));
      check(8'({freq_en, freq_sel}), 8'({rm[3][5], rm[3][5] ? rm[3][4:3] : 2'h0}));
      check(8'(diff_on), 8'(map6(rm[0]) & ~en_b));
   endtask
   task automatic do_reset(input logic [1:0] sel, input logic [6:0] a);
      rst_b <= 1'b0;
      addr_sel <= sel;
      pll_strap <= 2'($urandom);
      addr = a;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (30) @(posedge clk);
      rm = '{8'hDD, {pll_strap, 6'h06}, 8'hDF, 8'h07, 8'hFF, {REV, VEN}, {CLS, CODE}, 8'h08};
      check_outs();
   endtask
   task automatic probe(input logic [6:0] a);
      logic ack;
      host.start();
      host.put_byte({a, 1'b0}, ack);
      check(8'(ack), 8'h00);
      host.stop();
   endtask
   task automatic wr_block(input logic [7:0] n, input int cnt, input logic rnd, input logic [7:0] fv);
      logic ack;
      logic [7:0] d;
      host.start();
      host.put_byte({addr, 1'b0}, ack);
      check(8'(ack), 8'h01);
      host.put_byte(n, ack);
      check(8'(ack), 8'h01);
      host.put_byte(8'(cnt), ack);
      check(8'(ack), 8'h01);
      for (int i = 0; i < cnt; i++) begin
         d = rnd ? 8'($urandom) : fv;
         host.put_byte(d, ack);
         check(8'(ack), 8'h01);
         rm[n+i] = wval(n + i, d);
      end
      host.stop();
      repeat (30) @(posedge clk);
      check_outs();
   endtask
   task automatic rd_block(input logic [7:0] n, input int cnt);
      logic ack;
      logic [7:0] d;
      host.start();
      host.put_byte({addr, 1'b0}, ack);
      check(8'(ack), 8'h01);
      host.put_byte(n, ack);
      check(8'(ack), 8'h01);
      host.start();
      host.put_byte({addr, 1'b1}, ack);
      check(8'(ack), 8'h01);
      host.get_byte(1'b1, d);
      check(d, rm[7]);
      for (int i = 0; i < cnt; i++) begin
         host.get_byte(i < cnt - 1, d);
         check(d, rm[n+i]);
      end
      repeat (6) @(posedge clk);
      check(8'(dat_oe), 8'h00);
      host.stop();
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      void'($urandom(32'hD5C98950));
      do_reset(2'h0, 7'h6B);
      rd_block(8'h00, 8);
      probe(7'h6C);
      for (int k = 0; k < 4; k++) begin
         en_b <= 6'($urandom);
         wr_block(8'h00, 7, 1'b1, 8'h00);
         rd_block(8'h00, 8);
      end
      wr_block(8'h00, 1, 1'b0, 8'h00);
      wr_block(8'h01, 1, 1'b0, 8'h3B);
      wr_block(8'h03, 1, 1'b0, 8'hFE);
      wr_block(8'h07, 1, 1'b0, 8'hE3);
      rd_block(8'h05, 3);
      do_reset(2'h1, 7'h6C);
      addr_sel <= 2'h2;
      probe(7'h6B);
      rd_block(8'h00, 8);
      end_sim();
   end
   initial begin
      repeat (90000) @(posedge clk);
      num_errors++;
      end_sim();
   end
endmodule
`default_nettype wire
